/* File: core/tmr_timer2.sv */
// module: 16-bit capture/reload timer with APB register access
//
// Chosen here: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module tmr_timer2 (
	input  wire logic        i_core_clk,
	input  wire logic        i_sys_rst,
	input  wire logic        i_psel,
	input  wire logic        i_penable,
	input  wire logic        i_pwrite,
	input  wire logic [11:0] i_paddr,
	input  wire logic [31:0] i_pwdata,
	input  wire logic [3:0]  i_pstrb,
	output logic      [31:0] o_prdata,
	output logic             o_pready,
	output logic             o_pslverr,
	input  wire logic        i_ext_trigger_pin,
	input  wire logic        i_count_input_pin,
	input  wire logic        i_timer1_ovf,
	output logic             o_irq,
	output logic             o_rx_baud_tick,
	output logic             o_tx_baud_tick,
	output logic             o_clk_out
);
	import tmr_pkg::*;

	tmr_edge_if edges ();
	logic [7:0]  ctrl;
	logic [2:0]  mode;
	logic [1:0]  cfg;
	logic [15:0] rcap;
	logic [15:0] cnt;
	logic [3:0]  div;
	logic        tick;
	logic        baud;
	logic        down;
	logic        ovf_up;
	logic        ovf_dn;
	logic        ovf;
	logic        trig_ok;
	logic        do_cap;
	logic        do_reload;
	logic        wr;
	logic        rd;
	logic [7:0]  waddr;
	logic [7:0]  wbyte;
	logic        wr_ctrl;
	logic [15:0] next_cnt;
	logic [3:0]  next_div_max;

	tmr_pin_sync u_sync (
		.i_core_clk (i_core_clk),
		.i_sys_rst  (i_sys_rst),
		.i_trig_pin (i_ext_trigger_pin),
		.i_cnt_pin  (i_count_input_pin),
		.edges      (edges)
	);

	// bus decode: word address in byte lane 0; registers sit at offset*4
	assign waddr   = i_paddr[9:2];
	assign wbyte   = i_pwdata[7:0];
	assign wr      = i_psel & i_penable & i_pwrite & i_pstrb[0] & o_pready;
	assign rd      = i_psel & i_penable & ~i_pwrite & o_pready;
	assign wr_ctrl = wr && (waddr == ADDR_CTRL);

	// baud mode forced by either select bit
	assign baud = ctrl[CTL_RXB] | ctrl[CTL_TXB];

	// trigger ignored when disabled or generating baud
	assign trig_ok = ctrl[CTL_EXEN] & ~baud & edges.trig_fall;

	// direction only in auto-reload with down count
	// pin high counts up, pin low counts down
	assign down = mode[MOD_DOWN_COUNT_ENABLE] & ~ctrl[CTL_CPRL] & ~baud & ~edges.trig_lvl;

	// tick divider: slow or fast internal rate, or two clocks in baud mode
	always_comb begin
		if (baud) begin
			next_div_max = 4'(DIV_BAUD - 1);
		end else if (cfg[CFG_SPEED]) begin
			next_div_max = 4'(DIV_FAST - 1);
		end else begin
			next_div_max = 4'(DIV_SLOW - 1);
		end
	end

	// divider runs only while the timer runs
	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst || !ctrl[CTL_RUN] || div >= next_div_max) begin
			div <= 4'h0;
		end else begin
			div <= div + 4'h1;
		end
	end

	// no tick while run control is clear
	// internal tick or count pin falling edge
	always_comb begin
		if (!ctrl[CTL_RUN]) begin
			tick = 1'b0;
		end else if (!baud && ctrl[CTL_CT]) begin
			tick = edges.cnt_fall;
		end else begin
			tick = (div == next_div_max);
		end
	end

	// overflow up at all ones, down at reload match
	assign ovf_up = tick & ~down & (cnt == CNT_MAX);
	assign ovf_dn = tick & down & (cnt == rcap);
	assign ovf    = ovf_up | ovf_dn;

	// baud mode reloads after every overflow
	// reload mode reloads on up-count overflow or trigger
	// capture mode copies count on trigger
	// trigger reloads need run and are dropped while stopped; a stopped timer keeps its count unless a capture clears it
	assign do_reload = baud ? ovf_up : (~ctrl[CTL_CPRL] & (ovf_up | (trig_ok & ctrl[CTL_RUN])));
	assign do_cap    = ctrl[CTL_CPRL] & trig_ok;

	// next count: down-count underflow wraps to all ones
	always_comb begin
		if (do_reload) begin
			next_cnt = rcap;
		end else if (ovf_dn) begin
			next_cnt = CNT_MAX;
		end else if (down) begin
			next_cnt = cnt - 16'h0001;
		end else begin
			next_cnt = cnt + 16'h0001;
		end
	end

	// count register: software writes, then hardware
	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			cnt <= 16'h0000;
		end else if (wr && waddr == ADDR_CNT_L) begin
			cnt[7:0] <= wbyte;
		end else if (wr && waddr == ADDR_CNT_H) begin
			cnt[15:8] <= wbyte;
		end else if (do_cap && mode[MOD_ACLR]) begin
			// clear count once bytes are captured
			cnt <= 16'h0000;
		end else if (tick || do_reload) begin
			// holds otherwise, tick gated by run
			cnt <= next_cnt;
		end
	end

	// capture/reload register
	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			rcap <= 16'h0000;
		end else if (do_cap) begin
			rcap <= cnt;
		end else if (wr && waddr == ADDR_RCAP_L) begin
			rcap[7:0] <= wbyte;
		end else if (wr && waddr == ADDR_RCAP_H) begin
			rcap[15:8] <= wbyte;
		end
	end

	// control register: hardware sets beat software clears
	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			ctrl <= RST_BYTE;
		end else begin
			if (wr_ctrl) begin
				ctrl <= wbyte;
			end
			// hardware set only outside baud mode
			if (ovf && !baud) begin
				ctrl[CTL_OVF] <= 1'b1;
			end
			// trigger edge sets flag; overflow too when down-count enabled
			if (trig_ok || (ovf && mode[MOD_DOWN_COUNT_ENABLE] && !ctrl[CTL_CPRL] && !baud)) begin
				ctrl[CTL_EXF] <= 1'b1;
			end
		end
	end

	// mode and config registers
	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			mode <= 3'h0;
			cfg  <= 2'h0;
		end else begin
			if (wr && waddr == ADDR_MODE) begin
				mode <= wbyte[2:0];
			end
			if (wr && waddr == ADDR_CFG) begin
				cfg <= wbyte[1:0];
			end
		end
	end

	// read mux and ready; always zero wait states, unmapped reads zero
	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			o_prdata  <= 32'h00000000;
			o_pready  <= 1'b0;
			o_pslverr <= 1'b0;
		end else begin
			o_pready  <= i_psel & ~i_penable;
			o_pslverr <= 1'b0;
			o_prdata  <= 32'h00000000;
			if (i_psel && !i_penable && !i_pwrite) begin
				case (waddr)
					ADDR_CTRL:   o_prdata <= {24'h000000, ctrl};
					ADDR_MODE:   o_prdata <= {29'h0000000, mode};
					ADDR_RCAP_L: o_prdata <= {24'h000000, rcap[7:0]};
					ADDR_RCAP_H: o_prdata <= {24'h000000, rcap[15:8]};
					ADDR_CNT_L:  o_prdata <= {24'h000000, cnt[7:0]};
					ADDR_CNT_H:  o_prdata <= {24'h000000, cnt[15:8]};
					ADDR_CFG:    o_prdata <= {30'h0000000, cfg};
					ADDR_SER:    o_prdata <= {30'h0000000, ctrl[CTL_TXB], ctrl[CTL_RXB]};
					default:     o_prdata <= 32'h00000000;
				endcase
			end
		end
	end

	// outputs: interrupt, baud ticks, clock out all registered
	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			o_irq          <= 1'b0;
			o_rx_baud_tick <= 1'b0;
			o_tx_baud_tick <= 1'b0;
			o_clk_out      <= 1'b0;
		end else begin
			// either flag raises the request if enabled
			o_irq <= cfg[CFG_IEN] & (ctrl[CTL_OVF] | ctrl[CTL_EXF]);
			// receive uses this or timer 1 overflow
			o_rx_baud_tick <= ctrl[CTL_RXB] ? ovf_up : i_timer1_ovf;
			// transmit uses this or timer 1 overflow
			o_tx_baud_tick <= ctrl[CTL_TXB] ? ovf_up : i_timer1_ovf;
			// clock out toggles on overflow only when enabled
			if (!mode[MOD_OE]) begin
				o_clk_out <= 1'b0;
			end else if (ovf) begin
				o_clk_out <= ~o_clk_out;
			end
		end
	end

	// checks: the set wins over a same-cycle clear
	chk_ovf_set_rule: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
		ovf && !baud |=> ctrl[CTL_OVF])
		else $error("overflow flag not set on overflow");
	chk_ovf_baud_hold: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
		baud && !wr_ctrl && !ctrl[CTL_OVF] |=> !ctrl[CTL_OVF])
		else $error("overflow flag set in baud mode");
	chk_exf_trig_set: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
		trig_ok |=> ctrl[CTL_EXF])
		else $error("external flag missed trigger");
	chk_irq_follow: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
		cfg[CFG_IEN] && ctrl[CTL_EXF] |=> o_irq)
		else $error("interrupt not raised");
	chk_run_freeze: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
		!ctrl[CTL_RUN] && !wr && !do_cap |=> $stable(cnt))
		else $error("count moved while stopped");
	chk_baud_rate: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
		baud && ctrl[CTL_RUN] && $stable(baud) && tick |=> !tick)
		else $error("baud tick faster than two clocks");
	chk_baud_reload: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
		baud && ovf_up && !wr |=> cnt == $past(rcap))
		else $error("no reload after baud overflow");
	chk_cap_copy: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
		do_cap |=> rcap == $past(cnt))
		else $error("capture did not copy count");
	chk_cap_clear: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
		do_cap && mode[MOD_ACLR] && !wr |=> cnt == 16'h0000)
		else $error("count not cleared after capture");
	chk_trig_ignore: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
		!ctrl[CTL_EXEN] |-> !do_cap)
		else $error("trigger acted while disabled");
	chk_clkout_off: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
		!mode[MOD_OE] |=> !o_clk_out)
		else $error("clock out active while disabled");
	chk_ovf_up_set: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
		tick && !down && cnt == CNT_MAX && !baud |=> ctrl[CTL_OVF])
		else $error("overflow flag not set at all ones");
	chk_ovf_dn_set: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
		tick && down && cnt == rcap && !baud |=> ctrl[CTL_OVF])
		else $error("overflow flag not set at reload match");
	chk_irq_masked: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
		!cfg[CFG_IEN] |=> !o_irq)
		else $error("interrupt raised while disabled");
	chk_rx_source: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
		ctrl[CTL_RXB] |=> o_rx_baud_tick == $past(ovf_up))
		else $error("receive tick not from this timer");
	chk_tx_source: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
		!ctrl[CTL_TXB] |=> o_tx_baud_tick == $past(i_timer1_ovf))
		else $error("transmit tick not from timer 1");
	chk_baud_no_cap: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
		baud && !wr |=> rcap == $past(rcap))
		else $error("trigger acted in baud mode");
	chk_pin_count: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
		ctrl[CTL_RUN] && ctrl[CTL_CT] && !baud |-> tick == edges.cnt_fall)
		else $error("counter mode not counting pin edges");
	chk_reload_ovf: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
		!baud && !ctrl[CTL_CPRL] && ovf_up && !wr |=> cnt == $past(rcap))
		else $error("no reload after overflow");
	chk_reload_trig: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
		!ctrl[CTL_CPRL] && trig_ok && ctrl[CTL_RUN] && !wr |=> cnt == $past(rcap))
		else $error("no reload on trigger");
	chk_dir_up: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
		edges.trig_lvl |-> !down)
		else $error("counting down while pin high");
	chk_dir_down: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
		mode[MOD_DOWN_COUNT_ENABLE] && !ctrl[CTL_CPRL] && !baud && !edges.trig_lvl |-> down)
		else $error("not counting down while pin low");
	chk_clkout_toggle: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
		mode[MOD_OE] && ovf |=> o_clk_out != $past(o_clk_out))
		else $error("clock out did not toggle on overflow");
	chk_rcap_low_read: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
		rd && waddr == ADDR_RCAP_L |-> o_prdata[7:0] == $past(rcap[7:0]))
		else $error("low capture byte read wrong");
	chk_rcap_high_read: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
		rd && waddr == ADDR_RCAP_H |-> o_prdata[7:0] == $past(rcap[15:8]))
		else $error("high capture byte read wrong");
endmodule : tmr_timer2
`default_nettype wire

/* File: core/tmr_pkg.sv */
// package: register map, field positions and constants of the timer
package tmr_pkg;
	localparam logic [7:0] ADDR_CTRL   = 8'hC8;
	localparam logic [7:0] ADDR_MODE   = 8'hC9;
	localparam logic [7:0] ADDR_RCAP_L = 8'hCA;
	localparam logic [7:0] ADDR_RCAP_H = 8'hCB;
	localparam logic [7:0] ADDR_CNT_L  = 8'hCC;
	localparam logic [7:0] ADDR_CNT_H  = 8'hCD;
	localparam logic [7:0] ADDR_CFG    = 8'hD0; // speed select and interrupt enable
	localparam logic [7:0] ADDR_SER    = 8'hD4; // serial time-base status
	// control register bit positions
	localparam int CTL_OVF   = 7;
	localparam int CTL_EXF   = 6;
	localparam int CTL_RXB   = 5;
	localparam int CTL_TXB   = 4;
	localparam int CTL_EXEN  = 3;
	localparam int CTL_RUN   = 2;
	localparam int CTL_CT    = 1;
	localparam int CTL_CPRL  = 0;
	// mode register bit positions
	localparam int MOD_ACLR  = 2;
	localparam int MOD_OE    = 1;
	localparam int MOD_DOWN_COUNT_ENABLE  = 0;
	// config register bit positions
	localparam int CFG_SPEED = 0;
	localparam int CFG_IEN   = 1;
	localparam logic [7:0]  RST_BYTE = 8'h00;
	localparam logic [15:0] CNT_MAX  = 16'hFFFF;
	// internal tick dividers in core clocks
	localparam int DIV_SLOW  = 12;
	localparam int DIV_FAST  = 4;
	localparam int DIV_BAUD  = 2;
endpackage : tmr_pkg

/* File: core/tmr_edge_if.sv */
// interface: synchronised pin samples and their falling edges
`timescale 1ns/1ps
`default_nettype none
interface tmr_edge_if;
	logic trig_lvl;
	logic trig_fall;
	logic cnt_fall;
	modport src (output trig_lvl, output trig_fall, output cnt_fall);
	modport dst (input trig_lvl, input trig_fall, input cnt_fall);
endinterface : tmr_edge_if
`default_nettype wire

/* File: core/tmr_pin_sync.sv */
// module: pin synchronisers and falling-edge detectors
`timescale 1ns/1ps
`default_nettype none
module tmr_pin_sync (
	input  wire logic i_core_clk,
	input  wire logic i_sys_rst,
	input  wire logic i_trig_pin,
	input  wire logic i_cnt_pin,
	tmr_edge_if.src   edges
);
	logic [1:0] trig_s;
	logic [1:0] cnt_s;
	logic       trig_d;
	logic       cnt_d;
	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			trig_s <= 2'h3;
			cnt_s  <= 2'h3;
			trig_d <= 1'b1;
			cnt_d  <= 1'b1;
		end else begin
			trig_s <= {trig_s[0], i_trig_pin};
			cnt_s  <= {cnt_s[0], i_cnt_pin};
			trig_d <= trig_s[1];
			cnt_d  <= cnt_s[1];
		end
	end
	// falling edge: high sample followed by low sample
	assign edges.trig_lvl  = trig_s[1];
	assign edges.trig_fall = trig_d & ~trig_s[1];
	assign edges.cnt_fall  = cnt_d & ~cnt_s[1];
endmodule : tmr_pin_sync
`default_nettype wire

/* File: bench/tmr_pins_model.sv */
// partner model: drives the trigger and count pins
`timescale 1ns/1ps
`default_nettype none
module tmr_pins_model (
	input  wire logic i_core_clk,
	input  wire logic i_cnt_go,
	input  wire logic i_trig_go,
	input  wire logic i_trig_lvl,
	output logic      o_trig_pin,
	output logic      o_cnt_pin
);
	int cw = 0;
	int tw = 0;
	// high then low
	// low phase long enough to pass the two-flop synchroniser
	always @(posedge i_core_clk) begin
		cw <= i_cnt_go ? 8 : (cw > 0 ? cw - 1 : 0);
		tw <= i_trig_go ? 8 : (tw > 0 ? tw - 1 : 0);
		o_cnt_pin <= !(i_cnt_go || cw > 4);
		o_trig_pin <= i_trig_lvl && !(i_trig_go || tw > 4);
	end
endmodule : tmr_pins_model
`default_nettype wire

/* File: bench/tmr_timer2_bench.sv */
// testbench: timer registers, pin events and serial ticks
`timescale 1ns/1ps
`default_nettype none
module tmr_timer2_bench;
	import tmr_pkg::*;
	logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, t1 = 0, cgo = 0, tgo = 0, tlvl = 1;
	logic [11:0] paddr = 0;
	logic [31:0] pwd = 0, prd, seed = 32'h1700;
	logic rdy, irq, rxt, txt, tpin, cpin, perr, cko, rbe;
	logic [7:0] rb;
	int n_errors = 0, samples_checked = 0, k, m_cnt, m_rel;
	always #2.5 clk = ~clk;
	tmr_timer2 i_tmr_timer2 (.i_core_clk(clk), .i_sys_rst(rst), .i_psel(psel),
		.i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwd), .i_pstrb(4'hF),
		.o_prdata(prd), .o_pready(rdy), .o_pslverr(perr), .i_ext_trigger_pin(tpin),
		.i_count_input_pin(cpin), .i_timer1_ovf(t1), .o_irq(irq), .o_rx_baud_tick(rxt),
		.o_tx_baud_tick(txt), .o_clk_out(cko));
	tmr_pins_model i_tmr_pins_model (.i_core_clk(clk), .i_cnt_go(cgo), .i_trig_go(tgo),
		.i_trig_lvl(tlvl), .o_trig_pin(tpin), .o_cnt_pin(cpin));
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : xs
	task automatic stop_test();
		$display("checked %0d mismatches %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : stop_test
	task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch %0t reg got %h exp %h", $time, got, exp);
		end
	endtask : chk_reg
	task automatic chk_pin(input logic got, input logic exp);
		samples_checked++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch %0t pin got %b exp %b", $time, got, exp);
		end
	endtask : chk_pin
	// one setup cycle, then access until pready is sampled high
	task automatic apb(input logic w, input logic [7:0] off, input logic [7:0] wd);
		int n;
		@(posedge clk) {psel, pen, pwr, paddr, pwd} <= {2'b10, w, 2'b00, off, 2'b00, 24'h0, wd};
		@(posedge clk) pen <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (rdy !== 1'b1 && n < 20);
		rb = prd[7:0];
		rbe = perr;
		psel <= 1'b0;
		pen <= 1'b0;
		if (n >= 20) begin
			n_errors++;
			stop_test();
		end
	endtask : apb
	task automatic wr(input logic [7:0] off, input logic [7:0] d);
		apb(1'b1, off, d);
	endtask : wr
	task automatic rdc(input logic [7:0] off, input logic [7:0] exp);
		apb(1'b0, off, 8'h00);
		chk_reg(rb, exp);
		chk_pin(rbe, 1'b0);
	endtask : rdc
	// wraps at all-ones going up, at the reload value going down
	task automatic pulse(input logic cnt, input int n, input logic up);
		repeat (n) begin
			@(posedge clk) {cgo, tgo} <= {cnt, !cnt};
			@(posedge clk) {cgo, tgo} <= 2'b00;
			repeat (10) @(posedge clk);
			if (cnt && up) m_cnt = (m_cnt == 16'hFFFF) ? m_rel : m_cnt + 1;
			if (cnt && !up) m_cnt = (m_cnt == m_rel) ? 16'hFFFF : (m_cnt - 1) & 16'hFFFF;
		end
	endtask : pulse
	task automatic set_cnt(input int v);
		m_cnt = v & 16'hFFFF;
		wr(ADDR_CNT_L, m_cnt[7:0]);
		wr(ADDR_CNT_H, m_cnt[15:8]);
	endtask : set_cnt
	task automatic set_rel(input int v);
		m_rel = v & 16'hFFFF;
		wr(ADDR_RCAP_L, m_rel[7:0]);
		wr(ADDR_RCAP_H, m_rel[15:8]);
	endtask : set_rel
	task automatic cnt_chk();
		rdc(ADDR_CNT_L, m_cnt[7:0]);
		rdc(ADDR_CNT_H, m_cnt[15:8]);
	endtask : cnt_chk
	initial begin
		#300000;
		n_errors++;
		stop_test();
	end
	initial begin
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		for (k = 0; k < 6; k++) rdc(ADDR_CTRL + 8'(k), RST_BYTE);
		wr(8'h40, 8'h5A);
		rdc(8'h40, 8'h00);
		$display("test reset and map done");
		set_rel(xs());
		set_cnt(16'hFFFE);
		wr(ADDR_CFG, 8'h02);
		wr(ADDR_CTRL, 8'h06);
		pulse(1'b1, 3, 1'b1);
		cnt_chk();
		rdc(ADDR_CTRL, 8'h86);
		chk_pin(irq, 1'b1);
		wr(ADDR_CTRL, 8'h02);
		k = m_cnt; // stopped: the count must not move
		pulse(1'b1, 2, 1'b1);
		m_cnt = k;
		cnt_chk();
		chk_pin(irq, 1'b0);
		wr(ADDR_CTRL, 8'h42);
		repeat (2) @(posedge clk);
		chk_pin(irq, 1'b1);
		chk_pin(cko, 1'b0);
		wr(ADDR_MODE, 8'h02);
		wr(ADDR_CTRL, 8'h06);
		set_cnt(16'hFFFF);
		pulse(1'b1, 1, 1'b1);
		chk_pin(cko, 1'b1);
		$display("test up count done");
		wr(ADDR_MODE, 8'h01);
		tlvl <= 1'b0;
		set_cnt(m_rel + 1);
		wr(ADDR_CTRL, 8'h06);
		pulse(1'b1, 2, 1'b0);
		cnt_chk();
		rdc(ADDR_CTRL, 8'hC6);
		tlvl <= 1'b1;
		pulse(1'b1, 1, 1'b1);
		cnt_chk();
		$display("test down count done");
		wr(ADDR_MODE, 8'h00);
		wr(ADDR_CTRL, 8'h06);
		set_cnt(xs());
		pulse(1'b0, 1, 1'b1);
		rdc(ADDR_CTRL, 8'h06);
		wr(ADDR_CTRL, 8'h0E);
		pulse(1'b0, 1, 1'b1);
		m_cnt = m_rel;
		cnt_chk();
		rdc(ADDR_CTRL, 8'h4E);
		chk_pin(irq, 1'b1);
		wr(ADDR_CTRL, 8'h0F);
		set_cnt(xs());
		pulse(1'b0, 1, 1'b1);
		rdc(ADDR_RCAP_L, m_cnt[7:0]);
		rdc(ADDR_RCAP_H, m_cnt[15:8]);
		wr(ADDR_CTRL, 8'h0F);
		wr(ADDR_MODE, 8'h04);
		set_cnt(xs());
		pulse(1'b0, 1, 1'b1);
		m_cnt = 0;
		cnt_chk();
		$display("test trigger done");
		wr(ADDR_CTRL, 8'h00);
		wr(ADDR_MODE, 8'h00);
		// run window spans 40 clocks from write to write
		set_cnt(16'h0000);
		wr(ADDR_CFG, 8'h03);
		wr(ADDR_CTRL, 8'h04);
		repeat (37) @(posedge clk);
		wr(ADDR_CTRL, 8'h00);
		m_cnt = 40 / DIV_FAST;
		cnt_chk();
		wr(ADDR_CFG, 8'h02);
		set_cnt(16'h0000);
		wr(ADDR_CTRL, 8'h04);
		repeat (37) @(posedge clk);
		wr(ADDR_CTRL, 8'h00);
		m_cnt = 40 / DIV_SLOW;
		cnt_chk();
		$display("test timer rate done");
		set_rel(16'hFFF0);
		set_cnt(16'hFFF0);
		wr(ADDR_CTRL, 8'h26);
		for (k = 0; rxt !== 1'b1 && k < 200; k++) @(posedge clk);
		if (k >= 200) begin
			n_errors++;
			stop_test();
		end
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (rxt !== 1'b1 && k < 200);
		chk_reg(8'(k), 8'(DIV_BAUD * 16));
		rdc(ADDR_CTRL, 8'h26);
		wr(ADDR_CTRL, 8'h00);
		@(posedge clk) t1 <= 1'b1;
		@(posedge clk) t1 <= 1'b0;
		@(posedge clk);
		chk_pin(txt, 1'b1);
		chk_pin(rxt, 1'b1);
		$display("test baud done");
		stop_test();
	end
endmodule : tmr_timer2_bench
`default_nettype wire
